// ==== src/pwmct_pkg.sv ====
// package: register map, field layouts and constants for the pwm timer
package pwmct_pkg;
  localparam int unsigned NUM_CH   = 4;
  localparam logic [7:0] ADDR_ENABLE    = 8'h00;
  localparam logic [7:0] ADDR_POLARITY  = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL    = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h0c;
  localparam logic [7:0] ADDR_CENTER    = 8'h10;
  localparam logic [7:0] ADDR_CONTROL   = 8'h14;
  localparam logic [7:0] ADDR_SCALE_A   = 8'h18;
  localparam logic [7:0] ADDR_SCALE_B   = 8'h1c;
  localparam logic [7:0] ADDR_COUNTER0  = 8'h20;
  localparam logic [7:0] ADDR_PERIOD0   = 8'h30;
  localparam logic [7:0] ADDR_DUTY0     = 8'h40;
  localparam logic [7:0] ADDR_STATUS    = 8'h50;
  localparam int unsigned CTRL_FREEZE_BIT = 2;
  localparam int unsigned PRE_B_LSB       = 4;
  localparam int unsigned PRE_W           = 3;
  localparam int unsigned PRE_STAGES      = 8;
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [7:0] RST_PERIOD       = 8'hff;
  localparam logic [7:0] COUNT_ONE        = 8'h01;
  localparam logic [7:0] COUNT_ZERO       = 8'h00;
  localparam logic [7:0] COUNT_STEP       = 8'h01;
  localparam logic [31:0] ERR_DATA        = 32'h0000_0000;

  typedef enum logic [1:0] {
    PWMCT_APB_IDLE   = 2'b00,
    PWMCT_APB_SETUP  = 2'b01,
    PWMCT_APB_ACCESS = 2'b10
  } pwmct_apb_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pwmct_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pwmct_apb_rsp_t;
endpackage : pwmct_pkg

// ==== src/pwmct_core.sv ====
// module: four channel 8-bit pwm timer with prescaled and scaled clocks, apb slave
// Contract
// R1: output toggles whenever channel counter equals its 8-bit duty value
// R2: duty zero holds output low with polarity one, high with polarity zero
// R3: four clock sources a, b, scaled a, scaled b from bus clock
// R4: clocks a and b divide bus clock by 1 to 128 via own fields
// R5: scaled clock equals base clock divided by twice scale value
// R6: freeze-stop bit with freeze mode gates prescaler input, halting channels
// R7: prescaler input gated whenever all four channel enables are clear
// R8: writing a scale register reloads its down counter at once
// R9: scale counter counts to one, reloads, pulse toggles divide-by-two stage
// R10: channels 0,1 pick a or sa; channels 2,3 pick b or sb
// R11: each channel has 8-bit counter, period and duty; period sets length
// R12: enable drives output at once; waveform starts at next source clock tick
// R13: disabled channel counter holds its value
// R14: polarity one starts high then low at duty; zero starts low
// R15: software should not change clock settings while channels run
// R16: scale value zero divides by 256
// R17: counter write clears it, direction up, loads buffers, sets output
// R18: left aligned counts 0 to period-1, period match resets and reloads
// R19: center aligned counts up to period and down, reloads at zero
// R20: prescale field n divides bus clock by two to the power n
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module pwmct_core (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rstn_in,
  input  wire pwmct_pkg::pwmct_apb_req_t apb_req_in,
  input  wire logic                   freeze_mode_in,
  output pwmct_pkg::pwmct_apb_rsp_t   apb_rsp_out,
  output logic [3:0]                  pwm_out,
  output logic [3:0]                  pwm_oe_n_out
);
  import pwmct_pkg::*;

  // software registers
  logic [3:0]  channel_enable_bit;
  logic [3:0]  channel_polarity_bit;
  logic [3:0]  channel_clock_select_bit;
  logic [3:0]  center_align_bit;
  logic [7:0]  prescale_select_reg;
  logic [7:0]  module_control_reg;
  logic [7:0]  scale_a_value;
  logic [7:0]  scale_b_value;
  logic [7:0]  duty_buf   [NUM_CH];
  logic [7:0]  period_buf [NUM_CH];
  // active state
  logic [7:0]  channel_duty    [NUM_CH];
  logic [7:0]  channel_period  [NUM_CH];
  logic [7:0]  channel_counter [NUM_CH];
  logic [3:0]  count_down;
  logic [3:0]  wave;
  logic [3:0]  started;
  logic        freeze_s1;
  logic        freeze_s2;
  logic [6:0]  pre_cnt;
  logic [7:0]  scl_a_cnt;
  logic [7:0]  scl_b_cnt;
  logic        sa_div;
  logic        sb_div;
  logic        wr_stb;
  logic [3:0]  cnt_wr;
  logic [3:0]  per_wr;
  logic [3:0]  duty_wr;
  pwmct_apb_phase_t apb_phase;

  // bus write strobe only at the completing access edge
  assign wr_stb = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && apb_rsp_out.pready;

  function automatic logic [3:0] ch_hit(input logic [7:0] addr, input logic [7:0] base);
    logic [3:0] hit;
    hit = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (addr == base + 8'(4 * i)) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction : ch_hit

  function automatic logic pre_tick(input logic [6:0] cnt, input logic [2:0] sel);
    logic [7:0] mask;
    mask = (8'h01 << sel) - 8'h01;
    return ((cnt & mask[6:0]) == mask[6:0]);
  endfunction : pre_tick

  always_comb begin
    cnt_wr  = wr_stb ? ch_hit(apb_req_in.paddr, ADDR_COUNTER0) : 4'h0;
    per_wr  = wr_stb ? ch_hit(apb_req_in.paddr, ADDR_PERIOD0)  : 4'h0;
    duty_wr = wr_stb ? ch_hit(apb_req_in.paddr, ADDR_DUTY0)    : 4'h0;
  end

  // freeze level comes from the core, outside this logic
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      freeze_s1 <= 1'b0;
      freeze_s2 <= 1'b0;
    end else begin
      freeze_s1 <= freeze_mode_in;
      freeze_s2 <= freeze_s1;
    end
  end

  // prescaler input gate: a clock enable rather than a gated clock
  logic pre_run;
  assign pre_run = (|channel_enable_bit)                                           // see R7
                && !(module_control_reg[CTRL_FREEZE_BIT] && freeze_s2);          // see R6

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pre_cnt <= 7'h00;
    end else if (pre_run) begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  logic tick_a;
  logic tick_b;
  logic tick_sa;
  logic tick_sb;
  logic sa_pulse;
  logic sb_pulse;
  assign tick_a   = pre_run && pre_tick(pre_cnt, prescale_select_reg[PRE_W-1:0]);             // see R4, R20
  assign tick_b   = pre_run && pre_tick(pre_cnt, prescale_select_reg[PRE_B_LSB +: PRE_W]);    // see R4, R20
  assign sa_pulse = tick_a && (scl_a_cnt == COUNT_ONE);
  assign sb_pulse = tick_b && (scl_b_cnt == COUNT_ONE);
  // scaled clock tick on rising edge of divide-by-two stage
  assign tick_sa  = sa_pulse && !sa_div;                                                      // see R5
  assign tick_sb  = sb_pulse && !sb_div;                                                      // see R5

  // scale counters; zero loads as 256 by wrapping through 0x00
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      scl_a_cnt <= RST_BYTE;
      sa_div    <= 1'b0;
    end else if (wr_stb && apb_req_in.paddr == ADDR_SCALE_A) begin
      scl_a_cnt <= apb_req_in.pwdata[7:0];                                      // see R8
    end else if (tick_a) begin
      if (scl_a_cnt == COUNT_ONE) begin
        scl_a_cnt <= scale_a_value;                                             // see R9
        sa_div    <= !sa_div;                                                   // see R9
      end else begin
        scl_a_cnt <= scl_a_cnt - COUNT_STEP;                                    // see R16
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      scl_b_cnt <= RST_BYTE;
      sb_div    <= 1'b0;
    end else if (wr_stb && apb_req_in.paddr == ADDR_SCALE_B) begin
      scl_b_cnt <= apb_req_in.pwdata[7:0];                                      // see R8
    end else if (tick_b) begin
      if (scl_b_cnt == COUNT_ONE) begin
        scl_b_cnt <= scale_b_value;                                             // see R9
        sb_div    <= !sb_div;                                                   // see R9
      end else begin
        scl_b_cnt <= scl_b_cnt - COUNT_STEP;                                    // see R16
      end
    end
  end

  // per channel clock choice
  logic [3:0] ch_tick;
  always_comb begin
    ch_tick[0] = channel_clock_select_bit[0] ? tick_sa : tick_a;                // see R3, R10
    ch_tick[1] = channel_clock_select_bit[1] ? tick_sa : tick_a;                // see R10
    ch_tick[2] = channel_clock_select_bit[2] ? tick_sb : tick_b;                // see R10
    ch_tick[3] = channel_clock_select_bit[3] ? tick_sb : tick_b;                // see R3, R10
  end

  // control registers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      channel_enable_bit       <= 4'h0;
      channel_polarity_bit     <= 4'h0;
      channel_clock_select_bit <= 4'h0;
      center_align_bit         <= 4'h0;
      prescale_select_reg      <= RST_BYTE;
      module_control_reg       <= RST_BYTE;
      scale_a_value            <= RST_BYTE;
      scale_b_value            <= RST_BYTE;
    end else if (wr_stb) begin
      unique case (apb_req_in.paddr)
        ADDR_ENABLE:   channel_enable_bit       <= apb_req_in.pwdata[3:0];
        ADDR_POLARITY: channel_polarity_bit     <= apb_req_in.pwdata[3:0];
        ADDR_CLKSEL:   channel_clock_select_bit <= apb_req_in.pwdata[3:0];
        ADDR_CENTER:   center_align_bit         <= apb_req_in.pwdata[3:0];
        ADDR_PRESCALE: prescale_select_reg      <= apb_req_in.pwdata[7:0] & 8'h77;
        ADDR_CONTROL:  module_control_reg       <= apb_req_in.pwdata[7:0] & 8'h04;
        ADDR_SCALE_A:  scale_a_value            <= apb_req_in.pwdata[7:0];
        ADDR_SCALE_B:  scale_b_value            <= apb_req_in.pwdata[7:0];
        default:       ;
      endcase
    end
  end

  // channel timers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count_down <= 4'h0;
      wave       <= 4'h0;
      started    <= 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_buf[i]        <= RST_BYTE;
        period_buf[i]      <= RST_PERIOD;
        channel_duty[i]    <= RST_BYTE;
        channel_period[i]  <= RST_PERIOD;
        channel_counter[i] <= RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (duty_wr[i]) begin
          duty_buf[i] <= apb_req_in.pwdata[7:0];
        end
        if (per_wr[i]) begin
          period_buf[i] <= apb_req_in.pwdata[7:0];
        end
        // a disabled channel takes new values straight into the latches
        if (!channel_enable_bit[i]) begin
          started[i] <= 1'b0;                                                   // see R12
          if (duty_wr[i]) begin
            channel_duty[i] <= apb_req_in.pwdata[7:0];
          end
          if (per_wr[i]) begin
            channel_period[i] <= apb_req_in.pwdata[7:0];
          end
        end
        if (cnt_wr[i]) begin
          channel_counter[i] <= COUNT_ZERO;                                     // see R17
          count_down[i]      <= 1'b0;                                           // see R17
          channel_duty[i]    <= duty_buf[i];                                    // see R17
          channel_period[i]  <= period_buf[i];                                  // see R17
          wave[i]            <= 1'b0;                                           // see R17
        end else if (channel_enable_bit[i] && ch_tick[i]) begin                 // see R13
          started[i] <= 1'b1;                                                   // see R12
          if (!center_align_bit[i]) begin
            if (channel_counter[i] + COUNT_STEP >= channel_period[i]) begin
              channel_counter[i] <= COUNT_ZERO;                                 // see R18
              wave[i]            <= 1'b0;                                       // see R18
              channel_duty[i]    <= duty_buf[i];                                // see R18
              channel_period[i]  <= period_buf[i];                              // see R18
            end else begin
              channel_counter[i] <= channel_counter[i] + COUNT_STEP;            // see R11
              if (channel_counter[i] + COUNT_STEP == channel_duty[i]) begin
                wave[i] <= !wave[i];                                            // see R1
              end
            end
          end else begin
            if (!count_down[i]) begin
              if (channel_counter[i] >= channel_period[i]) begin
                count_down[i]      <= 1'b1;                                     // see R19
                channel_counter[i] <= channel_counter[i] - COUNT_STEP;
                if (channel_counter[i] - COUNT_STEP == channel_duty[i]) begin
                  wave[i] <= !wave[i];                                          // see R1, R19
                end
              end else begin
                channel_counter[i] <= channel_counter[i] + COUNT_STEP;
                if (channel_counter[i] + COUNT_STEP == channel_duty[i]) begin
                  wave[i] <= !wave[i];                                          // see R1, R19
                end
              end
            end else if (channel_counter[i] <= COUNT_ONE) begin
              channel_counter[i] <= COUNT_ZERO;
              count_down[i]      <= 1'b0;                                       // see R19
              wave[i]            <= 1'b0;
              channel_duty[i]    <= duty_buf[i];                                // see R19
              channel_period[i]  <= period_buf[i];                              // see R19
            end else begin
              channel_counter[i] <= channel_counter[i] - COUNT_STEP;
              if (channel_counter[i] - COUNT_STEP == channel_duty[i]) begin
                wave[i] <= !wave[i];                                            // see R1, R19
              end
            end
          end
        end
      end
    end
  end

  // output: wave 0 is the start state, polarity picks its level
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pwm_out      <= 4'h0;
      pwm_oe_n_out <= 4'hf;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        pwm_oe_n_out[i] <= !channel_enable_bit[i];                              // see R12
        if (channel_duty[i] == COUNT_ZERO) begin
          pwm_out[i] <= !channel_polarity_bit[i];                               // see R2
        end else if (!started[i]) begin
          pwm_out[i] <= channel_polarity_bit[i];                                // see R12, R14
        end else begin
          pwm_out[i] <= channel_polarity_bit[i] ^ wave[i];                      // see R14
        end
      end
    end
  end

  // apb slave: zero wait states, slverr on unmapped address
  logic        mapped;
  logic [31:0] rd_word;
  always_comb begin
    mapped  = 1'b1;
    rd_word = ERR_DATA;
    unique case (apb_req_in.paddr)
      ADDR_ENABLE:   rd_word[3:0] = channel_enable_bit;
      ADDR_POLARITY: rd_word[3:0] = channel_polarity_bit;
      ADDR_CLKSEL:   rd_word[3:0] = channel_clock_select_bit;
      ADDR_CENTER:   rd_word[3:0] = center_align_bit;
      ADDR_PRESCALE: rd_word[7:0] = prescale_select_reg;
      ADDR_CONTROL:  rd_word[7:0] = module_control_reg;
      ADDR_SCALE_A:  rd_word[7:0] = scale_a_value;
      ADDR_SCALE_B:  rd_word[7:0] = scale_b_value;
      ADDR_STATUS:   rd_word[7:0] = {started, count_down};
      default: begin
        mapped = |(ch_hit(apb_req_in.paddr, ADDR_COUNTER0) | ch_hit(apb_req_in.paddr, ADDR_PERIOD0)
                 | ch_hit(apb_req_in.paddr, ADDR_DUTY0));
        for (int i = 0; i < NUM_CH; i++) begin
          if (apb_req_in.paddr == ADDR_COUNTER0 + 8'(4 * i)) rd_word[7:0] = channel_counter[i];
          if (apb_req_in.paddr == ADDR_PERIOD0 + 8'(4 * i))  rd_word[7:0] = period_buf[i];
          if (apb_req_in.paddr == ADDR_DUTY0 + 8'(4 * i))    rd_word[7:0] = duty_buf[i];
        end
      end
    endcase
  end

  // ready is registered, so every transfer takes exactly two cycles, setup plus one access cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      apb_phase   <= PWMCT_APB_IDLE;
      apb_rsp_out <= '0;
    end else begin
      apb_rsp_out.pready <= 1'b0;
      apb_phase          <= PWMCT_APB_IDLE;
      if (apb_req_in.psel && !apb_req_in.penable) begin
        apb_phase           <= PWMCT_APB_SETUP;
        apb_rsp_out.pready  <= 1'b1;
        apb_rsp_out.pslverr <= !mapped;
        apb_rsp_out.prdata  <= apb_req_in.pwrite ? ERR_DATA : rd_word;
      end else if (apb_phase == PWMCT_APB_SETUP) begin
        apb_phase <= PWMCT_APB_ACCESS;
      end
    end
  end
endmodule : pwmct_core

// ==== sim/pwmct_sva.sv ====
// checker: concurrent assertions on the pwm timer ports
`timescale 1ns/1ns
module pwmct_sva (
  input wire logic                      sys_clk_in,
  input wire logic                      rstn_in,
  input wire pwmct_pkg::pwmct_apb_req_t apb_req_in,
  input wire logic                      freeze_mode_in,
  input wire pwmct_pkg::pwmct_apb_rsp_t apb_rsp_out,
  input wire logic [3:0]                pwm_out,
  input wire logic [3:0]                pwm_oe_n_out
);
  import pwmct_pkg::*;
  logic [3:0] en_sh;
  logic       frz_sh;
  logic [3:0] gap_cnt;
  logic [3:0] frz_cnt;
  logic [3:0] idle_cnt;
  logic       wr_acc;
  assign wr_acc = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & apb_rsp_out.pready;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) en_sh <= 4'h0;
    else if (wr_acc && apb_req_in.paddr == ADDR_ENABLE) en_sh <= apb_req_in.pwdata[3:0];
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) frz_sh <= 1'b0;
    else if (wr_acc && apb_req_in.paddr == ADDR_CONTROL) frz_sh <= apb_req_in.pwdata[CTRL_FREEZE_BIT];
  end
  // quiet time after bus access, so counter writes cannot move the pins
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || apb_req_in.psel) gap_cnt <= 4'h0;
    else if (gap_cnt != 4'hf) gap_cnt <= gap_cnt + 4'h1;
  end
  // freeze input passes a 2-flop synchroniser, hence the margin below
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !(frz_sh && freeze_mode_in)) frz_cnt <= 4'h0;
    else if (frz_cnt != 4'hf) frz_cnt <= frz_cnt + 4'h1;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || en_sh != 4'h0) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_setup;
    apb_req_in.psel && !apb_req_in.penable;
  endsequence
  sequence s_done;
    apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready;
  endsequence
  a_setup_ready: assert property (s_setup |=> apb_rsp_out.pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready)
    else $error("ready longer than one cycle");
  a_unmapped_err: assert property (s_done ##0 (apb_req_in.paddr > ADDR_STATUS) |-> apb_rsp_out.pslverr && (apb_req_in.pwrite || apb_rsp_out.prdata == ERR_DATA))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (s_done ##0 (apb_req_in.paddr <= ADDR_STATUS && apb_req_in.paddr[1:0] == 2'b00) |-> !apb_rsp_out.pslverr)
    else $error("mapped access refused");
  a_enable_back: assert property (s_done ##0 (!apb_req_in.pwrite && apb_req_in.paddr == ADDR_ENABLE) |-> apb_rsp_out.prdata == {28'h0, en_sh})
    else $error("enable readback wrong");
  a_oe_enable: assert property (s_done ##0 (apb_req_in.pwrite && apb_req_in.paddr == ADDR_ENABLE) |-> ##[1:2] pwm_oe_n_out == ~en_sh)
    else $error("output enable late");
  a_freeze_hold: assert property (frz_cnt >= 4'h6 && gap_cnt >= 4'h4 |-> $stable(pwm_out))
    else $error("pins move while frozen");
  a_idle_hold: assert property (idle_cnt >= 4'h6 && gap_cnt >= 4'h4 |-> $stable(pwm_out))
    else $error("pins move with all channels off");
endmodule : pwmct_sva
bind pwmct_core pwmct_sva pwmct_sva_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .apb_req_in(apb_req_in),
  .freeze_mode_in(freeze_mode_in), .apb_rsp_out(apb_rsp_out), .pwm_out(pwm_out), .pwm_oe_n_out(pwm_oe_n_out));

// ==== sim/pwmct_load.sv ====
// partner: load on the waveform pins, counting high cycles and rising edges
`timescale 1ns/1ns
module pwmct_load (
  input  wire logic [0:0] sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic [3:0] pwm_in,
  input  wire logic [3:0] oe_n_in,
  output logic [31:0]     high_out [4],
  output logic [31:0]     rise_out [4]
);
  logic [3:0] lvl;
  logic [3:0] lvl_q;
  // undriven pin falls to the pull-down level
  assign lvl = pwm_in & ~oe_n_in;
  always_ff @(posedge sys_clk_in) begin
    lvl_q <= rstn_in ? lvl : 4'h0;
    for (int i = 0; i < 4; i++) begin
      high_out[i] <= rstn_in ? high_out[i] + 32'(lvl[i]) : 32'h0;
      rise_out[i] <= rstn_in ? rise_out[i] + 32'(lvl[i] & ~lvl_q[i]) : 32'h0;
    end
  end
endmodule : pwmct_load

// ==== sim/pwmct_core_tb_top.sv ====
// testbench: apb driven waveform checks of the pwm timer
`timescale 1ns/1ns
module pwmct_core_tb_top;
  import pwmct_pkg::*;
  logic           sys_clk_in = 1'b0;
  logic           rstn_in = 1'b0;
  logic           freeze_mode_in = 1'b0;
  pwmct_apb_req_t req = '0;
  pwmct_apb_rsp_t rsp;
  logic [3:0]     pwm;
  logic [3:0]     oe_n;
  logic [31:0]    high [4];
  logic [31:0]    rise [4];
  logic [31:0]    dh [4];
  logic [31:0]    dr [4];
  logic [31:0]    rd;
  logic           er;
  logic [16:0]    lfsr = 17'h17e8f;
  int             err_count = 0;
  int             compares = 0;
  int             p;
  always #10 sys_clk_in = ~sys_clk_in;
  pwmct_core pwmct_core_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .apb_req_in(req),
    .freeze_mode_in(freeze_mode_in), .apb_rsp_out(rsp), .pwm_out(pwm), .pwm_oe_n_out(oe_n));
  pwmct_load pwmct_load_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .pwm_in(pwm),
    .oe_n_in(oe_n), .high_out(high), .rise_out(rise));
  function automatic logic [16:0] lfsr_next(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction : lfsr_next
  // waveform period in bus cycles; scale zero means 256
  function automatic int exp_cycles(input int pre, input int use_s, input int s, input int per, input int ca);
    int d;
    d = 1 << pre;
    if (use_s != 0) d = d * 2 * ((s == 0) ? 256 : s);
    return d * per * (ca + 1);
  endfunction : exp_cycles
  function automatic int exp_high(input int pol, input int per, input int dut, input int win);
    return win * ((pol != 0) ? dut : per - dut) / per;
  endfunction : exp_high
  task automatic final_report;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: read %h want %h", $time, got, exp);
    end
  endtask : chk_val
  // edge counts may be off by one at the window ends
  task automatic chk_near(input logic [31:0] got, input int exp);
    compares++;
    if ($isunknown(got) || int'(got) + 1 < exp || int'(got) > exp + 1) begin
      err_count++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask : chk_near
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 16) begin
      err_count++;
      $display("unexpected at %0t: no ready", $time);
      final_report();
    end
  endtask : apb
  task automatic measure(input int win);
    logic [31:0] h0 [4];
    logic [31:0] r0 [4];
    repeat (win / 4) @(posedge sys_clk_in);
    h0 = high;
    r0 = rise;
    repeat (win) @(posedge sys_clk_in);
    for (int i = 0; i < 4; i++) begin
      dh[i] = high[i] - h0[i];
      dr[i] = rise[i] - r0[i];
    end
  endtask : measure
  // clock settings change only with all channels off
  task automatic cfg(input logic [3:0] en, input logic [3:0] pol, input logic [7:0] per, input logic [7:0] dut,
                     input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, ADDR_ENABLE, 32'h0);
    apb(1'b1, a, d);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_PERIOD0 + 8'(4 * i), {24'h0, per});
      apb(1'b1, ADDR_DUTY0 + 8'(4 * i), {24'h0, dut});
      apb(1'b1, ADDR_COUNTER0 + 8'(4 * i), 32'h0);
    end
    apb(1'b1, ADDR_POLARITY, {28'h0, pol});
    apb(1'b1, ADDR_ENABLE, {28'h0, en});
  endtask : cfg
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    apb(1'b0, ADDR_PERIOD0, 32'h0);
    chk_val(rd, {24'h0, RST_PERIOD});
    apb(1'b1, 8'h60, 32'h5);
    apb(1'b0, 8'h60, 32'h0);
    chk_val({31'h0, er}, 32'h1);
    chk_val(rd, ERR_DATA);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b0, ADDR_DUTY0 + 8'(4 * i), 32'h0);
      chk_val(rd, {24'h0, RST_BYTE});
      apb(1'b1, ADDR_DUTY0 + 8'(4 * i), {15'h0, lfsr});
      apb(1'b0, ADDR_DUTY0 + 8'(4 * i), 32'h0);
      chk_val(rd, {24'h0, lfsr[7:0]});
    end
    for (p = 0; p < 2; p++) begin
      cfg(4'hf, (p != 0) ? 4'hf : 4'h0, 8'h04, 8'h01, ADDR_DUTY0 + 8'h0c, 32'h0);
      apb(1'b1, ADDR_DUTY0 + 8'h0c, 32'h0);
      apb(1'b1, ADDR_COUNTER0 + 8'h0c, 32'h0);
      measure(16);
      chk_near(dh[0], exp_high(p, 4, 1, 16));
      chk_near(dr[0], 16 / exp_cycles(0, 0, 0, 4, 0));
      chk_near(dh[3], exp_high(p, 4, 0, 16));
    end
    for (int n = 0; n < 8; n++) begin
      cfg(4'h5, 4'h5, 8'h02, 8'h01, ADDR_PRESCALE, 32'(n * 17));
      p = exp_cycles(n, 0, 0, 2, 0);
      measure(4 * p);
      chk_near(dr[0], 4);
      chk_near(dr[2], 4);
    end
    apb(1'b1, ADDR_ENABLE, 32'h0);
    apb(1'b1, ADDR_PRESCALE, 32'h0);
    apb(1'b1, ADDR_CLKSEL, 32'h6);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      p = (k == 0) ? 1 : (k == 1) ? 3 : (k == 2) ? int'(lfsr[7:0]) : 0;
      apb(1'b1, ADDR_ENABLE, 32'h0);
      apb(1'b1, ADDR_SCALE_A, 32'(p));
      cfg(4'h6, 4'h0, 8'h02, 8'h01, ADDR_SCALE_B, 32'(p));
      p = exp_cycles(0, 1, p, 2, 0);
      measure(4 * p);
      chk_near(dr[1], 4);
      chk_near(dr[2], 4);
    end
    cfg(4'h8, 4'h0, 8'h04, 8'h02, ADDR_CENTER, 32'h8);
    measure(32);
    chk_near(dh[3], exp_high(0, 4, 2, 32));
    chk_near(dr[3], 32 / exp_cycles(0, 0, 0, 4, 1));
    cfg(4'h1, 4'h0, 8'h04, 8'h02, ADDR_CENTER, 32'h0);
    freeze_mode_in <= 1'b1;
    measure(16);
    chk_near(dr[0], 4);
    apb(1'b1, ADDR_CONTROL, 32'(1 << CTRL_FREEZE_BIT));
    measure(16);
    chk_near(dr[0], 0);
    freeze_mode_in <= 1'b0;
    measure(16);
    chk_near(dr[0], 4);
    // channel 3 keeps the prescaler running, so a stopped counter 0 is its own doing
    apb(1'b1, ADDR_ENABLE, 32'h8);
    apb(1'b0, ADDR_ENABLE, 32'h0);
    chk_val(rd, 32'h8);
    apb(1'b0, ADDR_COUNTER0, 32'h0);
    p = int'(rd);
    repeat (20) @(posedge sys_clk_in);
    apb(1'b0, ADDR_COUNTER0, 32'h0);
    chk_val(rd, 32'(p));
    lfsr = lfsr_next(lfsr);
    cfg(4'h0, 4'h0, 8'h04, 8'h02, ADDR_COUNTER0, {15'h0, lfsr});
    repeat (20) @(posedge sys_clk_in);
    apb(1'b0, ADDR_COUNTER0, 32'h0);
    chk_val(rd, {24'h0, COUNT_ZERO});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk_val(rd, 32'h0);
    final_report();
  end
endmodule : pwmct_core_tb_top
